// ### verilog/stereo_trigger_pair.sv
// Functional notes
// R1: pair left and right frames only if timestamp difference within maximum
// R2: software sets maximum difference near half the frame period
// R3: two trigger outputs, primary and secondary, each with own enable
// R4: primary pulse train frequency programmable from 0.1 Hz to 200 Hz
// R5: primary pulse high time programmed in milliseconds, independent of rate; the code caps it at one microsecond below the period
// R6: triggers active high, high for programmed width, low between pulses
// R7: optional trigger-time timestamp replaces capture time on each result
// R8: cameras must answer every trigger when trigger timestamps are used
// R9: secondary output stays low unless primary is enabled too
// R10: secondary output runs at the primary frequency
// R11: secondary rising edge delayed from primary rising edge by offset
// R12: secondary pulse width programmed separately
// R13: both outputs timed from one shared period counter
`timescale 1ns/1ps
module stereo_trigger_pair #(
	parameter int COUNT_W = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire stereo_trig_pkg::word_t i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire stereo_trig_pkg::word_t i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output stereo_trig_pkg::word_t o_hrdata,
	input wire logic i_left_valid,
	input wire stereo_trig_pkg::word_t i_left_ts,
	output logic o_left_ready,
	input wire logic i_right_valid,
	input wire stereo_trig_pkg::word_t i_right_ts,
	output logic o_right_ready,
	output logic o_pair_valid,
	output stereo_trig_pkg::word_t o_pair_ts,
	output stereo_trig_pkg::word_t o_pair_left_ts,
	output stereo_trig_pkg::word_t o_pair_right_ts,
	output logic o_trig0,
	output logic o_trig1
);
	import stereo_trig_pkg::*;

	if (US_CYCLES < 2 || US_CYCLES > 255) begin : g_bad_div
		$error("microsecond divider out of range");
	end

	typedef struct packed {
		logic prim_en;
		logic sec_en;
		logic use_trig;
		word_t period_us;
		logic [15:0] pw0_ms;
		logic [15:0] pw1_ms;
		word_t offset_us;
		word_t max_diff_us;
		logic [7:0] div;
		word_t now_us;
		word_t phase;
		logic [7:0] ph_div;
		logic trig0;
		logic trig1;
		word_t trig_ts;
		logic ph_valid;
		logic ph_wr;
		logic [5:0] ph_ofs;
		word_t rdata;
	} top_state_t;

	top_state_t state_reg;
	top_state_t state_next;
	logic us_tick;
	logic ph_tick;
	word_t period_eff;
	word_t pw0_us;
	word_t pw1_us;
	word_t off_eff;
	word_t sec_phase;
	word_t phase_inc;
	logic addr_ok;

	pair_link_if lnk ();

	////////////////////////////////////////////////////////////////////////
	// pairing unit

	frame_pair_match #(
		.COUNT_W(COUNT_W)
	) u_match (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.lnk(lnk.match)
	);

	assign lnk.max_diff = state_reg.max_diff_us;
	assign lnk.use_trig = state_reg.use_trig;
	assign lnk.trig_ts = state_reg.trig_ts;
	assign lnk.left_valid = i_left_valid;
	assign lnk.left_ts = i_left_ts;
	assign lnk.right_valid = i_right_valid;
	assign lnk.right_ts = i_right_ts;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		state_next = state_reg;
		us_tick = (state_reg.div == 8'(US_CYCLES - 1));
		state_next.div = us_tick ? 8'h00 : state_reg.div + 8'h01;
		if (us_tick) begin
			state_next.now_us = state_reg.now_us + 32'h0000_0001;
		end

		// rate held within 0.1 Hz .. 200 Hz
		if (state_reg.period_us < MIN_PERIOD_US) begin // see R4
			period_eff = MIN_PERIOD_US;
		end else if (state_reg.period_us > MAX_PERIOD_US) begin
			period_eff = MAX_PERIOD_US;
		end else begin
			period_eff = state_reg.period_us;
		end
		// widths in ms, capped so a low gap always remains
		pw0_us = 32'(state_reg.pw0_ms) * 32'(MS_US); // see R5
		pw1_us = 32'(state_reg.pw1_ms) * 32'(MS_US); // see R12
		if (pw0_us >= period_eff) begin // see R6
			pw0_us = period_eff - 32'h0000_0001;
		end
		if (pw1_us >= period_eff) begin
			pw1_us = period_eff - 32'h0000_0001;
		end
		off_eff = (state_reg.offset_us < period_eff) ?
			state_reg.offset_us : 32'h0000_0000;

		// one phase counter serves both outputs
		// own divider: the first pulse after enable gets whole microseconds
		ph_tick = (state_reg.ph_div == 8'(US_CYCLES - 1));
		phase_inc = state_reg.phase + 32'h0000_0001; // see R13
		if (!state_reg.prim_en) begin
			state_next.ph_div = 8'h00;
			state_next.phase = 32'h0000_0000;
		end else begin
			state_next.ph_div = ph_tick ? 8'h00 : state_reg.ph_div + 8'h01;
			if (ph_tick) begin
				state_next.phase = (phase_inc >= period_eff) ?
					32'h0000_0000 : phase_inc; // see R10
			end
		end
		sec_phase = (state_next.phase >= off_eff) ?
			state_next.phase - off_eff :
			state_next.phase + period_eff - off_eff; // see R11
		state_next.trig0 = state_reg.prim_en &&
			(state_next.phase < pw0_us); // see R3
		state_next.trig1 = state_reg.prim_en && state_reg.sec_en &&
			(sec_phase < pw1_us); // see R9
		if (state_next.trig0 && !state_reg.trig0) begin
			state_next.trig_ts = state_reg.now_us; // see R7
		end

		// bus data phase: write
		if (state_reg.ph_valid && state_reg.ph_wr) begin
			case (state_reg.ph_ofs)
				OFS_CTRL: begin
					state_next.prim_en = i_hwdata[CTRL_PRIM_EN];
					state_next.sec_en = i_hwdata[CTRL_SEC_EN];
					state_next.use_trig = i_hwdata[CTRL_USE_TRIG];
				end
				OFS_PERIOD: state_next.period_us = i_hwdata;
				OFS_PW0: state_next.pw0_ms = i_hwdata[15:0];
				OFS_PW1: state_next.pw1_ms = i_hwdata[15:0];
				OFS_OFFSET: state_next.offset_us = i_hwdata;
				OFS_MAXDIFF: state_next.max_diff_us = i_hwdata;
				default: begin
				end
			endcase
		end

		// bus address phase
		addr_ok = (i_haddr[31:6] == 26'h0) && (i_haddr[1:0] == 2'h0);
		state_next.ph_valid = i_hsel && i_htrans[1] && i_hready;
		state_next.ph_wr = i_hwrite;
		state_next.ph_ofs = addr_ok ? i_haddr[5:0] : 6'h3c;
		if (state_next.ph_valid && !i_hwrite) begin
			case (state_next.ph_ofs)
				OFS_CTRL: begin
					state_next.rdata = 32'h0;
					state_next.rdata[CTRL_PRIM_EN] = state_next.prim_en;
					state_next.rdata[CTRL_SEC_EN] = state_next.sec_en;
					state_next.rdata[CTRL_USE_TRIG] = state_next.use_trig;
				end
				OFS_PERIOD: state_next.rdata = state_next.period_us;
				OFS_PW0: state_next.rdata = {16'h0, state_next.pw0_ms};
				OFS_PW1: state_next.rdata = {16'h0, state_next.pw1_ms};
				OFS_OFFSET: state_next.rdata = state_next.offset_us;
				OFS_MAXDIFF: state_next.rdata = state_next.max_diff_us;
				OFS_STATUS: begin
					state_next.rdata = 32'h0;
					state_next.rdata[STAT_TRIG0] = state_reg.trig0;
					state_next.rdata[STAT_TRIG1] = state_reg.trig1;
				end
				OFS_COUNTS: state_next.rdata =
					{lnk.drop_count, lnk.pair_count};
				OFS_TRIG_TS: state_next.rdata = state_reg.trig_ts;
				OFS_NOW: state_next.rdata = state_reg.now_us;
				default: state_next.rdata = 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= '0;
			state_reg.period_us <= RST_PERIOD_US;
			state_reg.pw0_ms <= RST_PW0_MS;
			state_reg.pw1_ms <= RST_PW1_MS;
			state_reg.offset_us <= RST_OFFSET_US;
			state_reg.max_diff_us <= RST_MAXDIFF_US;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = state_reg.rdata;
	assign o_trig0 = state_reg.trig0;
	assign o_trig1 = state_reg.trig1;
	assign o_left_ready = lnk.left_ready;
	assign o_right_ready = lnk.right_ready;
	assign o_pair_valid = lnk.pair_valid;
	assign o_pair_ts = lnk.pair_ts;
	assign o_pair_left_ts = lnk.pair_left_ts;
	assign o_pair_right_ts = lnk.pair_right_ts;

endmodule : stereo_trigger_pair

// ### verilog/stereo_trig_pkg.sv
package stereo_trig_pkg;

	typedef logic [31:0] word_t;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int US_NS = 1000;
	localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
	localparam int MS_US = 1000;
	localparam word_t MIN_PERIOD_US = 32'h0000_1388;
	localparam word_t MAX_PERIOD_US = 32'h0098_9680;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_PERIOD = 6'h04;
	localparam logic [5:0] OFS_PW0 = 6'h08;
	localparam logic [5:0] OFS_PW1 = 6'h0c;
	localparam logic [5:0] OFS_OFFSET = 6'h10;
	localparam logic [5:0] OFS_MAXDIFF = 6'h14;
	localparam logic [5:0] OFS_STATUS = 6'h18;
	localparam logic [5:0] OFS_COUNTS = 6'h1c;
	localparam logic [5:0] OFS_TRIG_TS = 6'h20;
	localparam logic [5:0] OFS_NOW = 6'h24;

	// control bits
	localparam int CTRL_PRIM_EN = 0;
	localparam int CTRL_SEC_EN = 1;
	localparam int CTRL_USE_TRIG = 2;

	// status bits, and the drop count field position in the counts register
	localparam int STAT_TRIG0 = 0;
	localparam int STAT_TRIG1 = 1;
	localparam int CNT_DROP_LSB = 16;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam word_t RST_PERIOD_US = 32'h0000_411a;
	localparam logic [15:0] RST_PW0_MS = 16'h0005;
	localparam logic [15:0] RST_PW1_MS = 16'h0005;
	localparam word_t RST_OFFSET_US = 32'h0000_0000;
	localparam word_t RST_MAXDIFF_US = 32'h0000_2710;

endpackage : stereo_trig_pkg

// ### verilog/pair_link_if.sv
`timescale 1ns/1ps
interface pair_link_if;
	import stereo_trig_pkg::*;

	word_t max_diff;
	logic use_trig;
	word_t trig_ts;
	logic left_valid;
	word_t left_ts;
	logic left_ready;
	logic right_valid;
	word_t right_ts;
	logic right_ready;
	logic pair_valid;
	word_t pair_ts;
	word_t pair_left_ts;
	word_t pair_right_ts;
	logic [15:0] pair_count;
	logic [15:0] drop_count;

	modport ctl (
		output max_diff, use_trig, trig_ts,
		output left_valid, left_ts, right_valid, right_ts,
		input left_ready, right_ready,
		input pair_valid, pair_ts, pair_left_ts, pair_right_ts,
		input pair_count, drop_count
	);

	modport match (
		input max_diff, use_trig, trig_ts,
		input left_valid, left_ts, right_valid, right_ts,
		output left_ready, right_ready,
		output pair_valid, pair_ts, pair_left_ts, pair_right_ts,
		output pair_count, drop_count
	);

endinterface : pair_link_if

// ### verilog/frame_pair_match.sv
`timescale 1ns/1ps
module frame_pair_match #(
	parameter int COUNT_W = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	pair_link_if.match lnk
);
	import stereo_trig_pkg::*;

	if (COUNT_W < 1 || COUNT_W > 16) begin : g_bad_width
		$error("COUNT_W must be 1..16");
	end

	typedef struct packed {
		logic lv;
		logic rv;
		word_t lts;
		word_t rts;
		logic out_valid;
		word_t out_ts;
		word_t out_lts;
		word_t out_rts;
		logic [COUNT_W-1:0] pairs;
		logic [COUNT_W-1:0] drops;
	} match_state_t;

	match_state_t state_reg;
	match_state_t state_next;
	word_t diff;

	always_comb begin
		state_next = state_reg;
		state_next.out_valid = 1'b0;
		diff = (state_reg.lts > state_reg.rts) ?
			state_reg.lts - state_reg.rts : state_reg.rts - state_reg.lts;
		if (state_reg.lv && state_reg.rv) begin
			if (diff <= lnk.max_diff) begin // see R1
				state_next.out_valid = 1'b1;
				state_next.out_lts = state_reg.lts;
				state_next.out_rts = state_reg.rts;
				state_next.out_ts = lnk.use_trig ? lnk.trig_ts :
					state_reg.lts; // see R7
				state_next.lv = 1'b0;
				state_next.rv = 1'b0;
				state_next.pairs = state_reg.pairs + 1'b1;
			end else begin
				// the older frame cannot pair any more; discard it
				if (state_reg.lts < state_reg.rts) begin
					state_next.lv = 1'b0;
				end else begin
					state_next.rv = 1'b0;
				end
				state_next.drops = state_reg.drops + 1'b1;
			end
		end
		if (lnk.left_valid && !state_reg.lv) begin
			state_next.lv = 1'b1;
			state_next.lts = lnk.left_ts;
		end
		if (lnk.right_valid && !state_reg.rv) begin
			state_next.rv = 1'b1;
			state_next.rts = lnk.right_ts;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign lnk.left_ready = !state_reg.lv;
	assign lnk.right_ready = !state_reg.rv;
	assign lnk.pair_valid = state_reg.out_valid;
	assign lnk.pair_ts = state_reg.out_ts;
	assign lnk.pair_left_ts = state_reg.out_lts;
	assign lnk.pair_right_ts = state_reg.out_rts;
	assign lnk.pair_count = 16'(state_reg.pairs);
	assign lnk.drop_count = 16'(state_reg.drops);

endmodule : frame_pair_match

// ### test/stereo_trig_asserts.sv
`timescale 1ns/1ps
module stereo_trig_asserts
	import stereo_trig_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire word_t i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire word_t i_hwdata,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic o_left_ready,
	input wire logic o_right_ready,
	input wire logic o_pair_valid,
	input wire word_t o_pair_left_ts,
	input wire word_t o_pair_right_ts,
	input wire logic o_trig0,
	input wire logic o_trig1
);
	logic wp;
	logic [5:0] wa;
	logic [1:0] ctl;
	word_t md, ofs, dif;
	assign dif = o_pair_left_ts > o_pair_right_ts ?
		o_pair_left_ts - o_pair_right_ts : o_pair_right_ts - o_pair_left_ts;
	// shadow of the settings written over the bus
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wp <= 1'b0;
			wa <= 6'h00;
			ctl <= 2'h0;
			md <= RST_MAXDIFF_US;
			ofs <= RST_OFFSET_US;
		end else begin
			wp <= i_hsel & i_htrans[1] & i_hwrite;
			wa <= i_haddr[5:0];
			if (wp && wa == OFS_CTRL) ctl <= i_hwdata[1:0];
			if (wp && wa == OFS_MAXDIFF) md <= i_hwdata;
			if (wp && wa == OFS_OFFSET) ofs <= i_hwdata;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	chk_pair_within: assert property (o_pair_valid |-> dif <= md)
		else $error("pair outside window");
	chk_pair_pulse: assert property (o_pair_valid |=> !o_pair_valid)
		else $error("pair pulse too long");
	chk_pair_free: assert property (
		o_pair_valid |-> o_left_ready && o_right_ready)
		else $error("slots not freed");
	chk_prim_off: assert property (
		!ctl[0] && !$past(ctl[0]) |-> !o_trig0)
		else $error("primary while off");
	chk_sec_gate: assert property (
		(!ctl[0] && !$past(ctl[0])) ||
		(!ctl[1] && !$past(ctl[1])) |-> !o_trig1)
		else $error("secondary without enables");
	chk_prim_start: assert property (
		$rose(ctl[0]) |-> ##[0:2] o_trig0)
		else $error("primary did not start");
	chk_sec_lock: assert property (
		$rose(o_trig0) && ctl[1] && ofs == 0 |-> o_trig1)
		else $error("secondary not in phase");
	chk_sec_delay: assert property (
		$rose(o_trig0) && ctl[1] && ofs != 0 |-> !o_trig1 [*8])
		else $error("secondary too early");
	chk_bus_okay: assert property (o_hreadyout && !o_hresp)
		else $error("bus not ready or error");
	cover property (o_pair_valid);
	cover property ($rose(o_trig1) && !$rose(o_trig0));
	cover property ($rose(o_trig0));
endmodule : stereo_trig_asserts

bind stereo_trigger_pair stereo_trig_asserts stereo_trig_asserts_i (.i_clk,
	.i_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .o_hreadyout,
	.o_hresp, .o_left_ready, .o_right_ready, .o_pair_valid, .o_pair_left_ts,
	.o_pair_right_ts, .o_trig0, .o_trig1);

// ### test/camera_pair_model.sv
`timescale 1ns/1ps
module camera_pair_model
	import stereo_trig_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_trig0,
	input wire logic i_trig1,
	input wire logic i_left_ready,
	input wire logic i_right_ready,
	input wire word_t i_base,
	input wire word_t i_skew,
	output logic o_left_valid,
	output word_t o_left_ts,
	output logic o_right_valid,
	output word_t o_right_ts
);
	logic p0, p1;
	word_t lt, rt;
	// idle data lines show the inverse of the last frame
	assign o_left_ts = o_left_valid ? lt : ~lt;
	assign o_right_ts = o_right_valid ? rt : ~rt;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			p0 <= 1'b0;
			p1 <= 1'b0;
			o_left_valid <= 1'b0;
			o_right_valid <= 1'b0;
		end else begin
			p0 <= i_trig0;
			p1 <= i_trig1;
			if (o_left_valid && i_left_ready) o_left_valid <= 1'b0;
			if (o_right_valid && i_right_ready) o_right_valid <= 1'b0;
			if (i_trig0 && !p0) begin
				o_left_valid <= 1'b1;
				lt <= i_base;
			end
			if (i_trig1 && !p1) begin
				o_right_valid <= 1'b1;
				rt <= i_base + i_skew;
			end
		end
	end
endmodule : camera_pair_model

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
	import stereo_trig_pkg::*;
	logic i_clk, i_rst, i_hwrite, i_left_valid, i_right_valid;
	logic o_hreadyout, o_hresp, o_left_ready, o_right_ready;
	logic o_pair_valid, o_trig0, o_trig1;
	logic [1:0] i_htrans;
	word_t i_haddr, i_hwdata, i_left_ts, i_right_ts, base, skew, rd, md;
	word_t o_hrdata, o_pair_ts, o_pair_left_ts, o_pair_right_ts, ofs;
	int mismatches, check_count, cyc, n;
	logic [5:0] ra[8] = '{OFS_CTRL, OFS_PERIOD, OFS_PW0, OFS_PW1, OFS_OFFSET,
		OFS_MAXDIFF, OFS_STATUS, 6'h28};
	word_t rv[8] = '{32'h0, RST_PERIOD_US, {16'h0, RST_PW0_MS}, 32'h7,
		RST_OFFSET_US, RST_MAXDIFF_US, 32'h0, 32'h0};
	stereo_trigger_pair stereo_trigger_pair_i (.i_clk, .i_rst, .i_hsel(1'b1),
		.i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2), .i_hwdata,
		.i_hready(o_hreadyout), .o_hreadyout, .o_hresp, .o_hrdata,
		.i_left_valid, .i_left_ts, .o_left_ready, .i_right_valid, .i_right_ts,
		.o_right_ready, .o_pair_valid, .o_pair_ts, .o_pair_left_ts,
		.o_pair_right_ts, .o_trig0, .o_trig1);
	camera_pair_model camera_pair_model_i (.i_clk, .i_rst, .i_trig0(o_trig0),
		.i_trig1(o_trig1), .i_left_ready(o_left_ready),
		.i_right_ready(o_right_ready), .i_base(base), .i_skew(skew),
		.o_left_valid(i_left_valid), .o_left_ts(i_left_ts),
		.o_right_valid(i_right_valid), .o_right_ts(i_right_ts));
	////////////////////////////////////////////////////////////////
	task automatic check(input word_t got, input word_t exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	// one single transfer; called just after a rising edge
	task automatic bus(input logic wr, input logic [5:0] a, input word_t d);
		i_haddr <= {26'h0, a};
		i_hwrite <= wr;
		i_htrans <= 2'h2;
		do @(posedge i_clk); while (!o_hreadyout);
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(posedge i_clk); while (!o_hreadyout);
		rd = o_hrdata;
	endtask : bus
	function automatic logic pairs(input word_t m, input word_t s);
		return (s[31] ? -s : s) <= m;
	endfunction : pairs
	task automatic pair_case(input word_t m, input word_t s, input logic ut);
		logic seen;
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		base <= $urandom_range(32'h7fff0000, 32'h100000);
		skew <= s;
		@(posedge i_clk);
		bus(1, OFS_MAXDIFF, m);
		// two microsecond ticks pass before the triggers start
		repeat (2 * US_CYCLES) @(posedge i_clk);
		bus(0, OFS_NOW, 32'h0);
		check(rd, 32'h2);
		bus(1, OFS_CTRL, {29'h0, ut, 2'h3});
		seen = 1'b0;
		repeat (40) begin
			@(posedge i_clk);
			if (o_pair_valid === 1'b1) seen = 1'b1;
		end
		check({31'h0, seen}, {31'h0, pairs(m, s)});
		if (seen) begin
			check(o_pair_left_ts, base);
			check(o_pair_right_ts, base + s);
			bus(0, OFS_TRIG_TS, 32'h0);
			check(rd, 32'h2);
			check(o_pair_ts, ut ? 32'h2 : base);
			bus(0, OFS_COUNTS, 32'h0);
			check(rd, 32'h1);
		end else begin
			bus(0, OFS_COUNTS, 32'h0);
			check(rd, 32'h0001_0000);
		end
	endtask : pair_case
	////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		{i_rst, i_htrans, i_hwrite, i_haddr, i_hwdata} = '0;
		i_rst = 1'b1;
		{base, skew} = '0;
		void'($urandom(88));
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		bus(1, OFS_PW1, 32'h7);
		bus(1, OFS_STATUS, 32'hffff_ffff);
		bus(1, 6'h28, 32'hffff_ffff);
		foreach (ra[k]) begin
			bus(0, ra[k], 32'h0);
			check(rd, rv[k]);
		end
		$display("registers done");
		bus(1, OFS_CTRL, 32'h2);
		repeat (300) @(posedge i_clk);
		check({31'h0, o_trig1}, 32'h0);
		ofs = $urandom_range(5, 2);
		bus(1, OFS_OFFSET, ofs);
		bus(1, OFS_CTRL, 32'h3);
		n = 0;
		while (o_trig1 !== 1'b1 && n < 2000) begin
			@(posedge i_clk);
			n++;
		end
		check({31'h0, o_trig0}, 32'h1);
		check(n, ofs * US_CYCLES + 1);
		bus(0, OFS_STATUS, 32'h0);
		check(rd, 32'h3);
		$display("triggers done");
		pair_case(32'h64, 32'h64, 1'b0);
		pair_case(32'h64, 32'hffff_ff9b, 1'b0);
		pair_case(32'h0, 32'h0, 1'b1);
		repeat (12) begin
			md = $urandom_range(500);
			pair_case(md, $urandom_range(2 * md + 2) - md - 1, $urandom_range(1));
		end
		$display("pairing done");
		conclude();
	end
endmodule : tb
